// [rih_cfg.svh]
`ifndef RIH_CFG_SVH
`define RIH_CFG_SVH

// command and response codes
`define RIH_CMD_IDENT 8'h00
`define RIH_CMD_READ 8'h06
`define RIH_RSP_IDENT 8'h01
`define RIH_RSP_READ 8'h07

// identify request codes and request data
`define RIH_RC_SYSCODE 8'h01
`define RIH_RC_PROTO 8'h02
`define RIH_RDATA_ALL 16'h0083
`define RIH_RDATA_LOW 16'h0001

// count ranges for services and blocks
`define RIH_CNT_MIN 8'h01
`define RIH_CNT_MAX 8'h0F

// status flags
`define RIH_SF_OK 8'h00
`define RIH_SF1_ERR 8'hFF
`define RIH_SF2_SVC_CNT 8'hA1
`define RIH_SF2_BLK_CNT 8'hA2
`define RIH_SF2_SVC_MIS 8'hA3

// frame layout
`define RIH_ID_LAST 8'h07
`define RIH_IDENT_BODY_LAST 8'h03
`define RIH_RC_POS 8'h02
`define RIH_IDENT_LEN 8'h11
`define RIH_IDENT_LEN_RD 8'h13
`define RIH_READ_ERR_LEN 8'h0B
`define RIH_READ_HDR_LEN 8'h0C
`define RIH_POS_ID_END 8'h08
`define RIH_POS_RTD 8'h09
`define RIH_POS_RTD_END 8'h10
`define RIH_POS_RDATA_HI 8'h11
`define RIH_POS_SF2 8'h0A
`define RIH_POS_BLKN 8'h0B
`define RIH_ELEM_SHORT_BIT 7

`endif

// [rih_pkg.sv]
package rih_pkg;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } rih_beat_t;

  typedef enum logic [3:0] {
    RIH_S_IDLE = 4'b0000,
    RIH_S_IDB = 4'b0001,
    RIH_S_ID = 4'b0010,
    RIH_S_SVCN = 4'b0011,
    RIH_S_SVC = 4'b0100,
    RIH_S_BLKN = 4'b0101,
    RIH_S_BE0 = 4'b0110,
    RIH_S_BE1 = 4'b0111,
    RIH_S_BE2 = 4'b1000,
    RIH_S_SKIP = 4'b1001,
    RIH_S_DROP = 4'b1010,
    RIH_S_TX = 4'b1011
  } rih_state_t;

endpackage : rih_pkg

// [rih_skid_buf.sv]
`timescale 1ns/1ps
module rih_skid_buf (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input rih_pkg::rih_beat_t in_beat,
  input wire logic in_valid,
  output logic in_ready,
  output rih_pkg::rih_beat_t out_beat,
  output logic out_valid,
  input wire logic out_ready
);
  rih_pkg::rih_beat_t spare_reg;
  logic spare_valid_reg;
  wire pop = out_valid & out_ready;
  wire push = in_valid & in_ready;

  // ready only looks at the spare slot, so it never depends on out_ready
  assign in_ready = ~spare_valid_reg;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      out_valid <= 1'b0;
      out_beat <= '0;
      spare_valid_reg <= 1'b0;
      spare_reg <= '0;
    end else if (!out_valid || pop) begin
      if (spare_valid_reg) begin
        out_beat <= spare_reg;
        spare_valid_reg <= 1'b0;
      end else begin
        out_beat <= in_beat;
        out_valid <= push;
      end
    end else if (push) begin
      spare_reg <= in_beat;
      spare_valid_reg <= 1'b1;
    end
  end
endmodule : rih_skid_buf

// [rih_block_store.sv]
`timescale 1ns/1ps
module rih_block_store (
  input wire logic ref_clk,
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data
);
  // sixteen blocks of sixteen bytes, no reset: contents come from the loader
  logic [7:0] mem [0:255];

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem[rd_addr];
endmodule : rih_block_store

// [rih_handler.sv]
`timescale 1ns/1ps
`include "rih_cfg.svh"
module rih_handler (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input rih_pkg::rih_beat_t rx_beat,
  input wire logic rx_valid,
  output logic rx_ready,
  output rih_pkg::rih_beat_t tx_beat,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic [63:0] card_id,
  input wire logic [63:0] resp_time,
  input wire logic [15:0] system_code,
  input wire logic rf_rate_select,
  input wire logic mem_wr_en,
  input wire logic [7:0] mem_wr_addr,
  input wire logic [7:0] mem_wr_data
);
  rih_pkg::rih_state_t st_reg, st_next;
  logic [7:0] cnt_reg, cnt_next;
  logic is_read_reg, is_read_next;
  logic [7:0] rc_reg, rc_next;
  logic [7:0] k_reg, k_next;
  logic [7:0] m_reg, m_next;
  logic [7:0] sf2_reg, sf2_next;
  logic [15:0] svc0_reg, svc0_next;
  logic mis_reg, mis_next;
  logic short_reg, short_next;
  logic [3:0] bi_reg, bi_next;
  logic [3:0] blk_reg [0:14];
  logic rx_ready_next;

  rih_pkg::rih_beat_t push_beat;
  logic buf_ready;
  logic [7:0] tx_byte;
  logic [7:0] mem_rd_data;

  wire take = rx_valid & rx_ready;
  wire [7:0] din = rx_beat.data;
  wire din_last = rx_beat.last;
  wire in_range = (din >= `RIH_CNT_MIN) && (din <= `RIH_CNT_MAX);
  wire [7:0] svc_end = {k_reg[6:0], 1'b0} - 8'h01;
  wire [7:0] svc_ref = cnt_reg[0] ? svc0_reg[7:0] : svc0_reg[15:8];
  wire svc_diff = (cnt_reg > 8'h01) && (din != svc_ref);
  wire elem_last = ({4'h0, bi_reg} == m_reg - 8'h01);
  wire rd_error = (sf2_reg != `RIH_SF_OK);
  wire rc_adds = (rc_reg == `RIH_RC_SYSCODE) || (rc_reg == `RIH_RC_PROTO);

  // request data and frame length for the pending answer
  wire [15:0] proto_data =
    rf_rate_select ? `RIH_RDATA_LOW : `RIH_RDATA_ALL;
  wire [15:0] req_data =
    (rc_reg == `RIH_RC_SYSCODE) ? system_code : proto_data;
  wire [7:0] ident_len =
    rc_adds ? `RIH_IDENT_LEN_RD : `RIH_IDENT_LEN;
  wire [7:0] read_len = rd_error ? `RIH_READ_ERR_LEN
    : `RIH_READ_HDR_LEN + {m_reg[3:0], 4'h0};
  wire [7:0] tx_len = is_read_reg ? read_len : ident_len;
  wire tx_end = (cnt_reg == tx_len - 8'h01);
  wire push_valid = (st_reg == rih_pkg::RIH_S_TX);
  wire push = push_valid & buf_ready;

  // byte slices of stored id and descriptor, most significant first
  logic [7:0] id_b [0:7];
  logic [7:0] rtd_b [0:7];
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_bytes
      assign id_b[g] = card_id[63 - 8 * g -: 8];
      assign rtd_b[g] = resp_time[63 - 8 * g -: 8];
    end
  endgenerate

  wire [2:0] id_idx = 3'(cnt_reg - 8'h01);
  wire [2:0] rtd_idx = 3'(cnt_reg - `RIH_POS_RTD);
  wire [7:0] blk_off = cnt_reg - `RIH_READ_HDR_LEN;
  wire [3:0] slot = blk_off[7:4];
  wire [7:0] mem_rd_addr = {blk_reg[slot], blk_off[3:0]};

  always_comb begin
    if (cnt_reg == 8'h00) begin
      tx_byte = is_read_reg ? `RIH_RSP_READ : `RIH_RSP_IDENT;
    end else if (cnt_reg <= `RIH_POS_ID_END) begin
      tx_byte = id_b[id_idx];
    end else if (!is_read_reg) begin
      if (cnt_reg <= `RIH_POS_RTD_END) begin
        tx_byte = rtd_b[rtd_idx];
      end else if (cnt_reg == `RIH_POS_RDATA_HI) begin
        tx_byte = req_data[15:8];
      end else begin
        tx_byte = req_data[7:0];
      end
    end else if (cnt_reg < `RIH_POS_SF2) begin
      tx_byte = rd_error ? `RIH_SF1_ERR : `RIH_SF_OK;
    end else if (cnt_reg == `RIH_POS_SF2) begin
      tx_byte = sf2_reg;
    end else if (cnt_reg == `RIH_POS_BLKN) begin
      tx_byte = m_reg;
    end else begin
      tx_byte = mem_rd_data;
    end
  end

  assign push_beat.data = tx_byte;
  assign push_beat.last = tx_end;

  // an answer goes out only after the frame's last byte has been seen;
  // a frame cut short before its fields are complete gets no answer unless a count or service error was already flagged
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    is_read_next = is_read_reg;
    rc_next = rc_reg;
    k_next = k_reg;
    m_next = m_reg;
    sf2_next = sf2_reg;
    svc0_next = svc0_reg;
    mis_next = mis_reg;
    short_next = short_reg;
    bi_next = bi_reg;
    case (st_reg)
      rih_pkg::RIH_S_IDLE: begin
        if (take) begin
          cnt_next = 8'h00;
          if (din == `RIH_CMD_IDENT) begin
            is_read_next = 1'b0;
            rc_next = 8'h00;
            st_next = din_last ? rih_pkg::RIH_S_IDLE : rih_pkg::RIH_S_IDB;
          end else if (din == `RIH_CMD_READ) begin
            is_read_next = 1'b1;
            sf2_next = `RIH_SF_OK;
            mis_next = 1'b0;
            bi_next = 4'h0;
            st_next = din_last ? rih_pkg::RIH_S_IDLE : rih_pkg::RIH_S_ID;
          end else begin
            st_next = din_last ? rih_pkg::RIH_S_IDLE : rih_pkg::RIH_S_DROP;
          end
        end
      end
      rih_pkg::RIH_S_IDB: begin
        if (take) begin
          cnt_next = cnt_reg + 8'h01;
          if (cnt_reg == `RIH_RC_POS) begin
            rc_next = din;
          end
          if (cnt_reg == `RIH_IDENT_BODY_LAST) begin
            cnt_next = 8'h00;
            st_next = din_last ? rih_pkg::RIH_S_TX : rih_pkg::RIH_S_SKIP;
          end else if (din_last) begin
            st_next = rih_pkg::RIH_S_IDLE;
          end
        end
      end
      rih_pkg::RIH_S_ID: begin
        if (take) begin
          cnt_next = cnt_reg + 8'h01;
          if (din_last) begin
            st_next = rih_pkg::RIH_S_IDLE;
          end else if (cnt_reg == `RIH_ID_LAST) begin
            st_next = rih_pkg::RIH_S_SVCN;
          end
        end
      end
      rih_pkg::RIH_S_SVCN: begin
        if (take) begin
          k_next = din;
          cnt_next = 8'h00;
          if (!in_range) begin
            sf2_next = `RIH_SF2_SVC_CNT;
            st_next = din_last ? rih_pkg::RIH_S_TX : rih_pkg::RIH_S_SKIP;
          end else begin
            st_next = din_last ? rih_pkg::RIH_S_IDLE : rih_pkg::RIH_S_SVC;
          end
        end
      end
      rih_pkg::RIH_S_SVC: begin
        if (take) begin
          cnt_next = cnt_reg + 8'h01;
          if (cnt_reg == 8'h00) begin
            svc0_next = {din, svc0_reg[7:0]};
          end else if (cnt_reg == 8'h01) begin
            svc0_next = {svc0_reg[15:8], din};
          end
          mis_next = mis_reg | svc_diff;
          if (cnt_reg == svc_end) begin
            cnt_next = 8'h00;
            if (mis_reg | svc_diff) begin
              sf2_next = `RIH_SF2_SVC_MIS;
              st_next = din_last ? rih_pkg::RIH_S_TX : rih_pkg::RIH_S_SKIP;
            end else begin
              st_next = din_last ? rih_pkg::RIH_S_IDLE : rih_pkg::RIH_S_BLKN;
            end
          end else if (din_last) begin
            st_next = rih_pkg::RIH_S_IDLE;
          end
        end
      end
      rih_pkg::RIH_S_BLKN: begin
        if (take) begin
          m_next = din;
          if (!in_range) begin
            sf2_next = `RIH_SF2_BLK_CNT;
            st_next = din_last ? rih_pkg::RIH_S_TX : rih_pkg::RIH_S_SKIP;
          end else begin
            st_next = din_last ? rih_pkg::RIH_S_IDLE : rih_pkg::RIH_S_BE0;
          end
        end
      end
      rih_pkg::RIH_S_BE0: begin
        if (take) begin
          short_next = din[`RIH_ELEM_SHORT_BIT];
          st_next = din_last ? rih_pkg::RIH_S_IDLE : rih_pkg::RIH_S_BE1;
        end
      end
      rih_pkg::RIH_S_BE1, rih_pkg::RIH_S_BE2: begin
        if (take) begin
          if (st_reg == rih_pkg::RIH_S_BE1 && !short_reg) begin
            st_next = din_last ? rih_pkg::RIH_S_IDLE : rih_pkg::RIH_S_BE2;
          end else if (elem_last) begin
            cnt_next = 8'h00;
            st_next = din_last ? rih_pkg::RIH_S_TX : rih_pkg::RIH_S_SKIP;
          end else begin
            bi_next = bi_reg + 4'h1;
            st_next = din_last ? rih_pkg::RIH_S_IDLE : rih_pkg::RIH_S_BE0;
          end
        end
      end
      rih_pkg::RIH_S_SKIP: begin
        if (take && din_last) begin
          cnt_next = 8'h00;
          st_next = rih_pkg::RIH_S_TX;
        end
      end
      rih_pkg::RIH_S_DROP: begin
        if (take && din_last) begin
          st_next = rih_pkg::RIH_S_IDLE;
        end
      end
      rih_pkg::RIH_S_TX: begin
        if (push) begin
          cnt_next = cnt_reg + 8'h01;
          if (tx_end) begin
            st_next = rih_pkg::RIH_S_IDLE;
          end
        end
      end
      default: begin
        st_next = rih_pkg::RIH_S_IDLE;
      end
    endcase
  end

  // input is held off while an answer is being built
  assign rx_ready_next = (st_next != rih_pkg::RIH_S_TX);
  wire blk_we = take && (st_reg == rih_pkg::RIH_S_BE1);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_reg <= rih_pkg::RIH_S_IDLE;
      cnt_reg <= 8'h00;
      is_read_reg <= 1'b0;
      rc_reg <= 8'h00;
      k_reg <= 8'h00;
      m_reg <= 8'h00;
      sf2_reg <= 8'h00;
      svc0_reg <= 16'h0000;
      mis_reg <= 1'b0;
      short_reg <= 1'b0;
      bi_reg <= 4'h0;
      rx_ready <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      is_read_reg <= is_read_next;
      rc_reg <= rc_next;
      k_reg <= k_next;
      m_reg <= m_next;
      sf2_reg <= sf2_next;
      svc0_reg <= svc0_next;
      mis_reg <= mis_next;
      short_reg <= short_next;
      bi_reg <= bi_next;
      rx_ready <= rx_ready_next;
    end
  end

  // only the low nibble of the block number addresses the 16-block store
  always_ff @(posedge ref_clk) begin
    if (blk_we) begin
      blk_reg[bi_reg] <= din[3:0];
    end
  end

  rih_block_store u_store (
    .ref_clk(ref_clk),
    .wr_en(mem_wr_en),
    .wr_addr(mem_wr_addr),
    .wr_data(mem_wr_data),
    .rd_addr(mem_rd_addr),
    .rd_data(mem_rd_data)
  );

  rih_skid_buf u_buf (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .in_beat(push_beat),
    .in_valid(push_valid),
    .in_ready(buf_ready),
    .out_beat(tx_beat),
    .out_valid(tx_valid),
    .out_ready(tx_ready)
  );
endmodule : rih_handler

// [rih_handler_assertions.sv]
`timescale 1ns/1ps
module rih_handler_assertions (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input rih_pkg::rih_beat_t rx_beat,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input rih_pkg::rih_beat_t tx_beat,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [63:0] card_id,
  input wire logic [63:0] resp_time,
  input wire logic [15:0] system_code,
  input wire logic rf_rate_select,
  input wire logic mem_wr_en,
  input wire logic [7:0] mem_wr_addr,
  input wire logic [7:0] mem_wr_data
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic [7:0] idx_reg, code_reg, rxi_reg, rc_reg, cmd_reg;
  wire tx_fire = tx_valid && tx_ready;
  wire rx_fire = rx_valid && rx_ready;
  wire [63:0] id_sh = card_id >> (11'd64 - {idx_reg, 3'b000});
  wire [63:0] rt_sh = resp_time >> (11'd128 - {idx_reg, 3'b000});
  wire [7:0] sc_byte = idx_reg[0] ? system_code[15:8] : system_code[7:0];
  wire ident_ans = code_reg == 8'h01 && tx_valid;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      idx_reg <= 8'h00;
      rxi_reg <= 8'h00;
    end else begin
      if (tx_fire) idx_reg <= tx_beat.last ? 8'h00 : idx_reg + 8'h01;
      if (rx_fire) rxi_reg <= rx_beat.last ? 8'h00 : rxi_reg + 8'h01;
    end
  end
  // captures only; meaningful once a frame has started
  always_ff @(posedge ref_clk) begin
    if (tx_fire && idx_reg == 8'h00) code_reg <= tx_beat.data;
    if (rx_fire && rxi_reg == 8'h00) cmd_reg <= rx_beat.data;
    if (rx_fire && rxi_reg == 8'h03) rc_reg <= rx_beat.data;
  end
  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_beat);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx beat dropped");
  property p_first_code;
    tx_valid && idx_reg == 8'h00 |-> tx_beat.data inside {8'h01, 8'h07};
  endproperty
  a_first_code: assert property (p_first_code)
    else $error("bad response code");
  property p_own_id;
    tx_valid && idx_reg inside {[1:8]} |-> tx_beat.data == id_sh[7:0];
  endproperty
  a_own_id: assert property (p_own_id) else $error("id byte wrong");
  property p_rtd;
    ident_ans && idx_reg inside {[9:16]} |-> tx_beat.data == rt_sh[7:0];
  endproperty
  a_rtd: assert property (p_rtd) else $error("time byte wrong");
  property p_ident_len;
    ident_ans && idx_reg == 8'h10 |->
      tx_beat.last == !(rc_reg inside {8'h01, 8'h02});
  endproperty
  a_ident_len: assert property (p_ident_len)
    else $error("identify length wrong");
  property p_syscode;
    ident_ans && rc_reg == 8'h01 && idx_reg inside {17, 18} |->
      tx_beat.data == sc_byte;
  endproperty
  a_syscode: assert property (p_syscode) else $error("system code");
  property p_rate;
    ident_ans && rc_reg == 8'h02 && idx_reg inside {17, 18} |->
      tx_beat.data == (idx_reg[0] ? 8'h00 : (rf_rate_select ? 8'h01 : 8'h83));
  endproperty
  a_rate: assert property (p_rate) else $error("rate data");
  property p_err_short;
    tx_valid && code_reg == 8'h07 && idx_reg == 8'h0A |->
      tx_beat.last == (tx_beat.data != 8'h00);
  endproperty
  a_err_short: assert property (p_err_short)
    else $error("read length wrong");
  property p_ident_prompt;
    rx_fire && rx_beat.last && cmd_reg == 8'h00 && rxi_reg >= 8'h04 |->
      ##2 tx_valid && tx_beat.data == 8'h01;
  endproperty
  a_ident_prompt: assert property (p_ident_prompt)
    else $error("identify not answered");
  property p_rx_hold_off;
    rx_fire && rx_beat.last && cmd_reg == 8'h00 && rxi_reg >= 8'h04 |=>
      !rx_ready;
  endproperty
  a_rx_hold_off: assert property (p_rx_hold_off)
    else $error("input not held off during answer");
endmodule : rih_handler_assertions

bind rih_handler rih_handler_assertions i_chk (.ref_clk, .sys_rst, .rx_beat,
  .rx_valid, .rx_ready, .tx_beat, .tx_valid, .tx_ready, .card_id, .resp_time,
  .system_code, .rf_rate_select, .mem_wr_en, .mem_wr_addr, .mem_wr_data);

// [rih_reader_model.sv]
`timescale 1ns/1ps
module rih_reader_model (
  input wire logic ref_clk,
  input wire logic slow,
  output rih_pkg::rih_beat_t rx_beat,
  output logic rx_valid,
  input wire logic rx_ready,
  input rih_pkg::rih_beat_t tx_beat,
  input wire logic tx_valid,
  output logic tx_ready
);
  logic [8:0] got[$];
  logic [8:0] beat_q;
  logic fire_q = 1'b0;
  logic [1:0] cyc = 2'h0;
  initial begin
    rx_beat = '0;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end
  // sampled mid-cycle so the edge's own updates cannot race the capture
  always @(negedge ref_clk) begin
    fire_q = tx_valid && tx_ready;
    beat_q = tx_beat;
  end
  // slow: accept one byte in four
  always @(posedge ref_clk) begin
    if (fire_q) got.push_back(beat_q);
    cyc <= cyc + 2'h1;
    tx_ready <= #1 !slow || cyc == 2'h0;
  end
  task automatic send(input logic [7:0] f[$]);
    foreach (f[i]) begin
      @(posedge ref_clk);
      #1;
      rx_beat = '{data: f[i], last: i == f.size() - 1};
      rx_valid = 1'b1;
      do @(negedge ref_clk); while (rx_ready !== 1'b1);
    end
    @(posedge ref_clk);
    #1;
    rx_valid = 1'b0;
    rx_beat.data = ~rx_beat.data;
  endtask : send
endmodule : rih_reader_model

// [rih_handler_test.sv]
`timescale 1ns/1ps
module rih_handler_test;
  typedef logic [7:0] rih_bq_t[$];
  localparam logic [63:0] own_id = 64'h1122334455667788;
  localparam logic [63:0] own_rt = 64'hA0B1C2D3E4F50617;
  localparam logic [15:0] own_sc = 16'h12FC;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic slow = 1'b0;
  logic rf_rate_select = 1'b0;
  logic mem_wr_en = 1'b0;
  logic [7:0] mem_wr_addr = 8'h00;
  logic [7:0] mem_wr_data = 8'h00;
  rih_pkg::rih_beat_t rx_beat, tx_beat;
  logic rx_valid, rx_ready, tx_valid, tx_ready;
  int n_fail = 0;
  int n_compared = 0;
  int cycles = 0;
  initial forever #5 ref_clk = ~ref_clk;
  rih_handler i_dut (.ref_clk, .sys_rst, .rx_beat, .rx_valid, .rx_ready,
    .tx_beat, .tx_valid, .tx_ready, .card_id(own_id), .resp_time(own_rt),
    .system_code(own_sc), .rf_rate_select, .mem_wr_en, .mem_wr_addr,
    .mem_wr_data);
  rih_reader_model i_rdr (.ref_clk, .slow, .rx_beat, .rx_valid, .rx_ready,
    .tx_beat, .tx_valid, .tx_ready);
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic expect_ans(input rih_bq_t e);
    int t;
    t = 0;
    while ((i_rdr.got.size() < e.size() || tx_valid) && t < 4000) begin
      @(negedge ref_clk);
      t++;
    end
    check(9'(i_rdr.got.size()), 9'(e.size()));
    foreach (e[i])
      check(i < i_rdr.got.size() ? i_rdr.got[i] : 9'h000,
        {e[i], i == e.size() - 1});
    i_rdr.got.delete();
  endtask : expect_ans
  function automatic rih_bq_t head(logic [7:0] c);
    rih_bq_t e;
    e = {c};
    for (int i = 7; i >= 0; i--) e.push_back(8'(own_id >> (8 * i)));
    return e;
  endfunction : head
  function automatic rih_bq_t ident(logic [7:0] rc, bit r1);
    rih_bq_t e;
    e = head(8'h01);
    for (int i = 7; i >= 0; i--) e.push_back(8'(own_rt >> (8 * i)));
    if (rc == 8'h01) e = {e, own_sc[15:8], own_sc[7:0]};
    if (rc == 8'h02) e = {e, 8'h00, r1 ? 8'h01 : 8'h83};
    return e;
  endfunction : ident
  // received id differs from the stored one on purpose
  function automatic rih_bq_t rd_cmd(int k, int m, bit dif);
    rih_bq_t f;
    f = {8'h06, 8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hE4, 8'hE5, 8'hE6, 8'hE7};
    f.push_back(8'(k));
    for (int i = 0; i < 2 * k; i++) f.push_back(i % 2 ? 8'h00 : 8'h09);
    if (dif) f[f.size() - 1] = 8'h01;
    f.push_back(8'(m));
    for (int i = 0; i < m; i++)
      if (i % 2) f = {f, 8'h00, 8'(i * 7 % 16), 8'h5A};
      else f = {f, 8'h80, 8'(i * 7 % 16)};
    return f;
  endfunction : rd_cmd
  function automatic rih_bq_t rd_ans(logic [7:0] sf2, int m);
    rih_bq_t e;
    e = head(8'h07);
    e = {e, sf2 == 8'h00 ? 8'h00 : 8'hFF, sf2};
    if (sf2 == 8'h00) begin
      e.push_back(8'(m));
      for (int i = 0; i < m * 16; i++)
        e.push_back(8'(((i / 16) * 7 % 16) * 16 + i % 16) ^ 8'h96);
    end
    return e;
  endfunction : rd_ans
  task automatic t_fill;
    for (int a = 0; a < 256; a++) begin
      @(posedge ref_clk);
      mem_wr_en <= #1 1'b1;
      mem_wr_addr <= #1 8'(a);
      mem_wr_data <= #1 8'(a) ^ 8'h96;
    end
    @(posedge ref_clk);
    mem_wr_en <= #1 1'b0;
    $display("test fill done");
  endtask : t_fill
  task automatic t_ident;
    logic [7:0] rcs[6] = '{8'h00, 8'h01, 8'h02, 8'h02, 8'h03, 8'hFF};
    // unknown or cut frames get no answer, so only the identify answer arrives
    i_rdr.send({8'h08, 8'h00});
    i_rdr.send({8'h00, 8'hFF, 8'hFF});
    i_rdr.send({8'h06, 8'hE0});
    foreach (rcs[i]) begin
      rf_rate_select <= #1 (i == 3);
      i_rdr.send({8'h00, 8'hFF, 8'hFF, rcs[i], 8'h00});
      expect_ans(ident(rcs[i], i == 3));
    end
    $display("test identify done");
  endtask : t_ident
  task automatic t_read;
    slow <= #1 1'b1;
    i_rdr.send(rd_cmd(15, 15, 1'b0));
    expect_ans(rd_ans(8'h00, 15));
    slow <= #1 1'b0;
    i_rdr.send(rd_cmd(1, 1, 1'b0));
    expect_ans(rd_ans(8'h00, 1));
    $display("test read done");
  endtask : t_read
  task automatic t_read_err;
    int k[6] = '{0, 16, 3, 2, 2, 2};
    int m[6] = '{1, 1, 1, 0, 16, 0};
    bit d[6] = '{0, 0, 1, 0, 0, 1};
    logic [7:0] s[6] = '{8'hA1, 8'hA1, 8'hA3, 8'hA2, 8'hA2, 8'hA3};
    foreach (k[i]) begin
      i_rdr.send(rd_cmd(k[i], m[i], d[i]));
      expect_ans(rd_ans(s[i], m[i]));
    end
    $display("test read errors done");
  endtask : t_read_err
  task automatic tally_and_finish;
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    sys_rst <= #1 1'b0;
    t_fill;
    t_ident;
    t_read;
    t_read_err;
    tally_and_finish;
  end
endmodule : rih_handler_test
